// File: common/eeprom_port_pkg.sv
// Constants, states and rule summary for the two-wire EEPROM slave port.
// Assumes one 250 MHz logic clock; bus lines arrive asynchronously.
// How it works
// - Page writes accept up to eight bytes in an aligned eight-byte page.
// - Received bytes reach storage only on stop; otherwise discarded.
// - Write address increments only low three bits, wrapping inside the page.
// - Extra bytes overwrite earlier ones; only the last eight are committed.
// - Address is not acknowledged while the internal write runs.
// - Internal address holds last accessed address plus one, wrapping.
// - Current-address read shifts out the byte at the internal address.
// - Master acknowledge requests the next byte; read address wraps FFh to 00h.
// - On master no-acknowledge the device releases the data line.
// - Data falling with clock high is a start, aborting any transfer.
// - Data rising with clock high is a stop, returning to idle.
// - Data changes only while clock is low; one bit per clock pulse.
// - Bytes go MSB first; receiver drives low through the ninth pulse.
// - Address byte acknowledged only with control code 1010 and matching bits.
// - Device answers a fixed auxiliary address and a programmable main one.
// - Last address bit one selects read, zero selects write.
// - Works at 100 kHz and 400 kHz bus clocks.
// - Repeated start ends the transfer and restarts address reception.
// - Main address is A2h unless the source select picks the stored byte.
// - On address mismatch, no acknowledge and idle until next start.
// - A write sends one eight-bit word address, then data, each acknowledged.
// - During the internal write only address polling is answered, with no ack.
package eeprom_port_pkg;

    localparam logic [3:0]  CTRL_CODE      = 4'ha;
    localparam logic [7:0]  MAIN_ADDR_DFLT = 8'ha2;
    localparam logic [7:0]  AUX_ADDR       = 8'ha0;
    localparam logic [7:0]  CFG_ADDR_LOC   = 8'h8c;
    localparam int          PAGE_BYTES     = 8;
    localparam int          MEM_BYTES      = 256;
    localparam int          FIFO_DEPTH     = 4;
    localparam int          WRITE_CYCLES   = 1000;
    localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
    localparam logic [2:0]  FILT_RESET     = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WORD,
        ST_WDATA,
        ST_ACK,
        ST_RDATA,
        ST_RMACK
    } port_state_e;

endpackage : eeprom_port_pkg

// File: core/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    // Fill side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // Drain side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             do_push;
    logic             do_pop;

    assign in_ready_out  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    assign out_valid_out = wr_ptr != rd_ptr;
    assign out_data_out  = store[rd_ptr[AW-1:0]];
    assign do_push       = in_valid_in && in_ready_out;
    assign do_pop        = out_valid_out && out_ready_in;

    always_ff @(posedge ref_clk_in)
    begin
        if (do_push)
        begin
            store[wr_ptr[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

endmodule : byte_fifo
`default_nettype wire

// File: core/eeprom_port.sv
// Two-wire slave port with page-write buffer and internal storage array.
// Assumes an open-drain bus with pull-ups; master drives the clock line.
`timescale 1ns/1ps
`default_nettype none
module eeprom_port
    import eeprom_port_pkg::*;
#(
    parameter int WRITE_LEN = WRITE_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    // Bus lines
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_out,
    // Configuration and status
    input  wire logic address_source_select_in,
    output logic      write_busy_out
);

    // ------------------------------------------------------------
    // Input synchronisers and glitch filter
    // ------------------------------------------------------------
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] sel_s;
    logic [2:0] scl_h;
    logic [2:0] sda_h;
    logic       scl_f;
    logic       sda_f;
    logic       scl_p;
    logic       sda_p;

    // Level changes only once three samples agree
    function automatic logic filt(input logic [2:0] h, input logic cur);
        filt = (h == 3'h7) ? 1'b1 : (h == 3'h0) ? 1'b0 : cur;
    endfunction : filt

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            sel_s <= 2'h0;
            scl_h <= FILT_RESET;
            sda_h <= FILT_RESET;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end
        else
        begin
            scl_s <= {scl_s[0], scl_in};
            sda_s <= {sda_s[0], sda_in};
            sel_s <= {sel_s[0], address_source_select_in};
            scl_h <= {scl_h[1:0], scl_s[1]};
            sda_h <= {sda_h[1:0], sda_s[1]};
            scl_f <= filt(scl_h, scl_f);
            sda_f <= filt(sda_h, sda_f);
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise  = scl_f && !scl_p;
    assign scl_fall  = !scl_f && scl_p;
    assign start_det = scl_f && scl_p && sda_p && !sda_f;
    assign stop_det  = scl_f && scl_p && !sda_p && sda_f;

    // ------------------------------------------------------------
    // Storage and address match
    // ------------------------------------------------------------
    logic [7:0] mem [MEM_BYTES];
    logic [7:0] main_addr;

    assign main_addr = sel_s[1] ? mem[CFG_ADDR_LOC] : MAIN_ADDR_DFLT;

    function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] m);
        addr_hit = (b[7:4] == CTRL_CODE)
                && ((b[7:1] == m[7:1]) || (b[7:1] == AUX_ADDR[7:1]));
    endfunction : addr_hit

    // ------------------------------------------------------------
    // Protocol state machine
    // ------------------------------------------------------------
    port_state_e state;
    port_state_e ack_next;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [7:0]  addr;
    logic        push;
    logic [15:0] push_word;
    logic        fifo_in_ready;

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state      <= ST_IDLE;
            ack_next   <= ST_IDLE;
            bitcnt     <= 4'h0;
            shreg      <= 8'h00;
            addr       <= 8'h00;
            push       <= 1'b0;
            push_word  <= 16'h0000;
            sda_oe_out <= 1'b0;
        end
        else
        begin
            push <= 1'b0;
            if (start_det)
            begin
                state      <= ST_ADDR;
                bitcnt     <= 4'h0;
                sda_oe_out <= 1'b0;
            end
            else if (stop_det)
            begin
                state      <= ST_IDLE;
                sda_oe_out <= 1'b0;
            end
            else if (scl_rise)
            begin
                case (state)
                    ST_ADDR, ST_WORD, ST_WDATA:
                    begin
                        shreg  <= {shreg[6:0], sda_f};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    ST_RMACK:
                    begin
                        if (!sda_f)
                        begin
                            state    <= ST_ACK;
                            ack_next <= ST_RDATA;
                        end
                        else
                        begin
                            state <= ST_IDLE;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
            else if (scl_fall)
            begin
                // Outputs change only after a falling clock edge
                case (state)
                    ST_ADDR:
                    begin
                        if (bitcnt == BITS_PER_BYTE)
                        begin
                            if (addr_hit(shreg, main_addr) && !write_busy_out)
                            begin
                                sda_oe_out <= 1'b1;
                                state      <= ST_ACK;
                                ack_next   <= shreg[0] ? ST_RDATA : ST_WORD;
                            end
                            else
                            begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_WORD:
                    begin
                        if (bitcnt == BITS_PER_BYTE)
                        begin
                            sda_oe_out <= 1'b1;
                            addr       <= shreg;
                            state      <= ST_ACK;
                            ack_next   <= ST_WDATA;
                        end
                    end
                    ST_WDATA:
                    begin
                        if (bitcnt == BITS_PER_BYTE)
                        begin
                            // A full buffer refuses the byte with no acknowledge
                            if (fifo_in_ready)
                            begin
                                sda_oe_out <= 1'b1;
                                push       <= 1'b1;
                                push_word  <= {addr, shreg};
                                addr       <= {addr[7:3], addr[2:0] + 3'h1};
                                state      <= ST_ACK;
                                ack_next   <= ST_WDATA;
                            end
                            else
                            begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        bitcnt <= 4'h0;
                        state  <= ack_next;
                        if (ack_next == ST_RDATA)
                        begin
                            shreg      <= mem[addr];
                            sda_oe_out <= ~mem[addr][7];
                            addr       <= addr + 8'h01;
                            bitcnt     <= 4'h1;
                        end
                        else
                        begin
                            sda_oe_out <= 1'b0;
                        end
                    end
                    ST_RDATA:
                    begin
                        if (bitcnt == BITS_PER_BYTE)
                        begin
                            sda_oe_out <= 1'b0;
                            state      <= ST_RMACK;
                        end
                        else
                        begin
                            sda_oe_out <= ~shreg[6];
                            shreg      <= {shreg[6:0], 1'b0};
                            bitcnt     <= bitcnt + 4'h1;
                        end
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    // Open drain: the pin is only ever pulled low
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sda_out <= 1'b0;
        end
        else
        begin
            sda_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Page buffer, commit and internal write timer
    // ------------------------------------------------------------
    logic        fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic        fifo_out_ready;
    logic [7:0]  pbuf [PAGE_BYTES];
    logic [7:0]  pvalid;
    logic [4:0]  page_base;
    logic        data_seen;
    logic        commit_pend;
    logic        commit_go;
    logic [15:0] busy_cnt;

    // Draining stalls during the internal write
    assign fifo_out_ready = !write_busy_out;
    assign commit_go      = commit_pend && !fifo_out_valid && !write_busy_out;

    byte_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in   (ref_clk_in),
        .rst_in       (rst_in),
        .in_valid_in  (push),
        .in_data_in   (push_word),
        .in_ready_out (fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out (fifo_out_data),
        .out_ready_in (fifo_out_ready)
    );

    always_ff @(posedge ref_clk_in)
    begin
        if (fifo_out_valid && fifo_out_ready)
        begin
            pbuf[fifo_out_data[10:8]] <= fifo_out_data[7:0];
        end
        if (commit_go)
        begin
            for (int i = 0; i < PAGE_BYTES; i++)
            begin
                if (pvalid[i])
                begin
                    mem[{page_base, 3'(i)}] <= pbuf[i];
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pvalid      <= 8'h00;
            page_base   <= 5'h00;
            data_seen   <= 1'b0;
            commit_pend <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                data_seen <= 1'b1;
            end
            if (fifo_out_valid && fifo_out_ready)
            begin
                pvalid[fifo_out_data[10:8]] <= 1'b1;
                page_base                   <= fifo_out_data[15:11];
            end
            if (stop_det && data_seen)
            begin
                commit_pend <= 1'b1;
                data_seen   <= 1'b0;
            end
            else if (start_det && !commit_pend)
            begin
                // Data not closed by a stop is dropped
                pvalid    <= 8'h00;
                data_seen <= 1'b0;
            end
            if (commit_go)
            begin
                pvalid      <= 8'h00;
                commit_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            write_busy_out <= 1'b0;
            busy_cnt       <= 16'h0000;
        end
        else if (commit_go)
        begin
            write_busy_out <= 1'b1;
            busy_cnt       <= 16'(WRITE_LEN - 1);
        end
        else if (write_busy_out)
        begin
            if (busy_cnt == 16'h0000)
            begin
                write_busy_out <= 1'b0;
            end
            else
            begin
                busy_cnt <= busy_cnt - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence addr_done_s;
        state == ST_ADDR && scl_fall && bitcnt == BITS_PER_BYTE && !start_det && !stop_det;
    endsequence

    sequence master_nack_s;
        state == ST_RMACK && scl_rise && sda_f && !start_det && !stop_det;
    endsequence

    busy_nack_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        addr_done_s ##0 write_busy_out |=> !sda_oe_out && state == ST_IDLE)
        else $error("address acknowledged while busy");
    addr_ack_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        addr_done_s ##0 (!write_busy_out && addr_hit(shreg, main_addr)) |=> sda_oe_out)
        else $error("matching address not acknowledged");
    start_abort_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        start_det |=> state == ST_ADDR && bitcnt == 4'h0 && !sda_oe_out)
        else $error("start did not restart address phase");
    stop_idle_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        stop_det && !start_det |=> state == ST_IDLE && !sda_oe_out)
        else $error("stop did not return to idle");
    page_wrap_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        push |-> addr[7:3] == push_word[15:11] && addr[2:0] == push_word[10:8] + 3'h1)
        else $error("write address left its page");
    read_inc_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        state == ST_ACK && scl_fall && ack_next == ST_RDATA && !start_det && !stop_det
        |=> addr == $past(addr) + 8'h01 && sda_oe_out == ~mem[$past(addr)][7])
        else $error("read address not advanced");
    nack_release_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        master_nack_s |=> !sda_oe_out [*3])
        else $error("data line held after master nack");
    oe_stable_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        scl_f && scl_p && !start_det && !stop_det |=> $stable(sda_oe_out))
        else $error("data line changed while clock high");
    commit_busy_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        commit_go |=> write_busy_out && pvalid == 8'h00 && !commit_pend)
        else $error("commit did not start internal write");
    busy_end_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        write_busy_out && busy_cnt == 16'h0000 && !commit_go |=> !write_busy_out)
        else $error("busy did not clear at count end");

endmodule : eeprom_port
`default_nettype wire

// File: test/bus_master.sv
// Two-wire bus master model: drives the clock and open-drain data of the port.
// Assumes the bench resolves the data wire with a pull-up; SCL rests high outside frames.
`timescale 1ns/1ps
`default_nettype none
module bus_master (
    // Clock
    input  wire logic ref_clk_in,
    // Bus
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out
);
    // ----------------------------------------
    // Bus phases, 10 clocks each for an 80 ns bus clock
    // ----------------------------------------
    initial scl_out = 1'b1;
    initial sda_out = 1'b1;

    task automatic w(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask : w

    // Data held 3 clocks past the fall so the slave's filter sees SCL first
    task automatic bit_io(input logic b, output logic r);
        w(3);
        sda_out <= b;
        w(7);
        scl_out <= 1'b1;
        w(10);
        r = sda_in;
        scl_out <= 1'b0;
    endtask : bit_io

    task automatic start();
        w(3);
        sda_out <= 1'b1;
        w(7);
        scl_out <= 1'b1;
        w(10);
        sda_out <= 1'b0;
        w(10);
        scl_out <= 1'b0;
    endtask : start

    task automatic stop();
        w(3);
        sda_out <= 1'b0;
        w(7);
        scl_out <= 1'b1;
        w(10);
        sda_out <= 1'b1;
        w(10);
    endtask : stop

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = (r === 1'b0);
    endtask : wbyte

    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(~mack, r);
    endtask : rbyte
endmodule : bus_master
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the two-wire EEPROM port, driven by a bus master model.
// Assumes a pulled-up data line and a shortened internal write length.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import eeprom_port_pkg::*;
;
    localparam int WLEN = 400;
    logic       ref_clk_in;
    logic       rst_in;
    logic       sel;
    logic       scl;
    logic       m_sda;
    logic       sda_o;
    logic       sda_oe;
    logic       busy;
    wire logic  sda_wire;
    int         errors = 0;
    int         samples_checked = 0;
    logic       ack;
    logic [7:0] d;

    // Pull-up unless either party pulls low
    assign sda_wire = m_sda & (sda_oe ? sda_o : 1'b1);

    eeprom_port #(.WRITE_LEN(WLEN)) dut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_o), .sda_oe_out(sda_oe),
        .address_source_select_in(sel), .write_busy_out(busy));
    bus_master m (.ref_clk_in(ref_clk_in), .sda_in(sda_wire), .scl_out(scl), .sda_out(m_sda));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic idle();
        repeat (WLEN + 100) if (busy !== 1'b0) @(posedge ref_clk_in);
        chk({7'h0, busy}, 8'h00);
    endtask : idle

    task automatic wr(input logic [7:0] dev, input logic [7:0] wa, input int n,
                      input logic [7:0] base, input logic fin);
        m.start();
        m.wbyte(dev, ack);
        chk({7'h0, ack}, 8'h01);
        m.wbyte(wa, ack);
        chk({7'h0, ack}, 8'h01);
        for (int k = 0; k < n; k++)
        begin
            m.wbyte(base + 8'(k), ack);
            chk({7'h0, ack}, 8'h01);
        end
        if (fin)
        begin
            m.stop();
            repeat (20) if (busy !== 1'b1) @(posedge ref_clk_in);
            chk({7'h0, busy}, 8'h01);
        end
    endtask : wr

    task automatic rd(input logic [7:0] dev, input logic [7:0] wa, input logic rnd,
                      input logic [7:0] exp[$]);
        m.start();
        if (rnd)
        begin
            m.wbyte(dev, ack);
            m.wbyte(wa, ack);
            chk({7'h0, ack}, 8'h01);
            m.start();
        end
        m.wbyte(dev | 8'h01, ack);
        chk({7'h0, ack}, 8'h01);
        foreach (exp[k])
        begin
            m.rbyte(k < exp.size() - 1, d);
            chk(d, exp[k]);
        end
        chk({7'h0, sda_oe}, 8'h00);
        m.stop();
    endtask : rd

    task automatic poll(input logic [7:0] dev, input logic [7:0] exp);
        m.start();
        m.wbyte(dev, ack);
        chk({7'h0, ack}, exp);
    endtask : poll

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic byte_write_poll();
        wr(MAIN_ADDR_DFLT, 8'h10, 1, 8'h3c, 1'b1);
        poll(MAIN_ADDR_DFLT, 8'h00);
        m.stop();
        idle();
        poll(MAIN_ADDR_DFLT, 8'h01);
        m.stop();
    endtask : byte_write_poll

    task automatic page_wrap();
        wr(MAIN_ADDR_DFLT, 8'h06, 9, 8'h00, 1'b1);
        idle();
        rd(MAIN_ADDR_DFLT, 8'h00, 1'b1, '{8'h02, 8'h03, 8'h04, 8'h05,
                                          8'h06, 8'h07, 8'h08, 8'h01});
    endtask : page_wrap

    task automatic read_wrap();
        wr(MAIN_ADDR_DFLT, 8'hff, 1, 8'h5a, 1'b1);
        idle();
        rd(MAIN_ADDR_DFLT, 8'hff, 1'b1, '{8'h5a, 8'h02});
        rd(MAIN_ADDR_DFLT, 8'h00, 1'b0, '{8'h03});
    endtask : read_wrap

    task automatic discard_on_restart();
        wr(MAIN_ADDR_DFLT, 8'h20, 1, 8'h11, 1'b1);
        idle();
        wr(MAIN_ADDR_DFLT, 8'h20, 1, 8'h22, 1'b0);
        rd(MAIN_ADDR_DFLT, 8'h20, 1'b1, '{8'h11});
    endtask : discard_on_restart

    task automatic address_match();
        poll(8'hb2, 8'h00);
        poll(8'ha4, 8'h00);
        poll(AUX_ADDR, 8'h01);
        m.stop();
    endtask : address_match

    task automatic stored_address();
        wr(MAIN_ADDR_DFLT, CFG_ADDR_LOC, 1, 8'ha6, 1'b1);
        idle();
        @(posedge ref_clk_in);
        sel <= 1'b1;
        repeat (5) @(posedge ref_clk_in);
        poll(MAIN_ADDR_DFLT, 8'h00);
        poll(8'ha6, 8'h01);
        m.stop();
    endtask : stored_address

    initial
    begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    initial
    begin
        rst_in = 1'b1;
        sel = 1'b0;
        repeat (5) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (10) @(posedge ref_clk_in);
        byte_write_poll();
        page_wrap();
        read_wrap();
        discard_on_restart();
        address_match();
        stored_address();
        end_sim();
    end

    // Runs take about 13k clocks; over four times that means a hang
    initial
    begin
        repeat (60000) @(posedge ref_clk_in);
        errors++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
